/* File: hdl/pcseq_pkg.sv */
// constants, types and helpers shared by the sequencer and its return stack
// assumes a single core clock domain and an avalon-mm master with 32-bit data
package pcseq_pkg;

  // widths
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int LATCH_W = 5;
  localparam int BYTE_W = 8;
  localparam int DADDR_W = 9;
  localparam int AVS_ADDR_W = 5;
  localparam int AVS_DATA_W = 32;
  localparam int AVS_BE_W = 4;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;

  // register byte offsets, one aligned word each
  localparam logic [AVS_ADDR_W-1:0] OFS_INDIRECT = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] OFS_PC_LOW = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] OFS_STATUS = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] OFS_FSP = 5'h0c;
  localparam logic [AVS_ADDR_W-1:0] OFS_PC_LATCH = 5'h10;

  // field positions
  localparam int BANK_BIT = 7;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;

  // values after reset
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [BYTE_W-1:0] FSP_RST = 8'h00;
  localparam logic BANK_RST = 1'b0;
  localparam logic [STACK_PTR_W-1:0] SP_RST = 3'h0;

  // fixed values
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [STACK_PTR_W-1:0] SP_ONE = 3'h1;
  localparam logic [BYTE_W-1:0] FSP_SELF = 8'h00;
  localparam logic [BYTE_W-1:0] INDIRECT_SELF_DATA = 8'h00;

  // commands from the instruction decoder, one per instruction cycle
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_STEP,
    CMD_PCL_WRITE,
    CMD_GOTO,
    CMD_CALL,
    CMD_RETURN,
    CMD_RETURN_WITH_LITERAL,
    CMD_RETURN_FROM_INTERRUPT,
    CMD_VECTOR
  } seq_cmd_e;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_MEM,
    BUS_DONE
  } bus_state_e;

  // byte placed in the low lane of a bus word
  function automatic logic [AVS_DATA_W-1:0] byte_word(input logic [BYTE_W-1:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // bank bit above the pointer gives the data address
  function automatic logic [DADDR_W-1:0] indirect_addr(input logic bank,
                                                       input logic [BYTE_W-1:0] ptr);
    indirect_addr = {bank, ptr};
  endfunction

endpackage

/* File: hdl/return_stack.sv */
// circular eight-entry return stack of full program counter values
// assumes push and pop never arrive in the same cycle
`timescale 1ns/100ps
module return_stack
  import pcseq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [pcseq_pkg::PC_W-1:0] push_pc,
  output logic [pcseq_pkg::PC_W-1:0] top_pc
);

  logic [PC_W-1:0] mem_r [STACK_DEPTH];
  logic [PC_W-1:0] mem_nxt [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] sp_r;
  logic [STACK_PTR_W-1:0] sp_nxt;

  // newest entry sits one below the write pointer
  assign top_pc = mem_r[sp_r - SP_ONE];

  // pointer wraps silently both ways, no overflow flag
  always_comb
  begin
    mem_nxt = mem_r;
    sp_nxt = sp_r;
    if (push)
    begin
      mem_nxt[sp_r] = push_pc; // ninth push lands on the first slot
      sp_nxt = sp_r + SP_ONE;
    end
    else if (pop)
    begin
      sp_nxt = sp_r - SP_ONE; // underflow just wraps
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_r <= SP_RST;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        mem_r[i] <= PC_RST;
      end
    end
    else
    begin
      sp_r <= sp_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule // return_stack

/* File: hdl/pc_sequencer.sv */
// program counter, page latch, return stack and indirect data pointer
// assumes the decoder issues one command per cycle and data memory answers mem_req
`timescale 1ns/100ps

// Functional notes
// - the program counter is 13 bits and its low byte is a readable, writable register.
// - counter bits 12..8 are never readable and a bus write loads them only through the high latch.
// - every reset clears the upper counter bits.
// - a write to the low byte loads the upper counter bits from latch bits 4..0 together.
// - call and goto take 11 bits from the instruction and the top two from latch bits 4..3.
// - the counter spans 8K words split into 2K pages reachable by one call or goto.
// - the return stack has eight 13-bit entries and its pointer is hidden from software.
// - a call pushes the counter plus one and an interrupt vectoring pushes the counter onto the stack.
// - return, return_with_literal and return_from_interrupt each pop the stack.
// - pushes and pops never touch the high latch.
// - the stack is circular, so the ninth push overwrites the first.
// - stack overflow and underflow raise no flag and wrap silently.
// - a return restores all 13 counter bits from the stack regardless of the page bits.
// - the indirect_data_port has no storage and redirects to the register the pointer selects.
// - an indirect read with the pointer at zero returns 00h.
// - an indirect write with the pointer at zero changes no register.
// - the indirect address is the bank select bit above the 8-bit pointer, 9 bits in all.
module pc_sequencer
  import pcseq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [pcseq_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pcseq_pkg::AVS_DATA_W-1:0] avs_writedata,
  input wire logic [pcseq_pkg::AVS_BE_W-1:0] avs_byteenable,
  output logic [pcseq_pkg::AVS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // instruction decoder
  input wire pcseq_pkg::seq_cmd_e seq_cmd,
  input wire logic [pcseq_pkg::LIT_W-1:0] branch_lit,
  input wire logic [pcseq_pkg::BYTE_W-1:0] pcl_data,
  output logic [pcseq_pkg::PC_W-1:0] pc_out,
  // data memory behind the indirect port
  output logic mem_req,
  output logic mem_we,
  output logic [pcseq_pkg::DADDR_W-1:0] mem_addr,
  output logic [pcseq_pkg::BYTE_W-1:0] mem_wdata,
  input wire logic [pcseq_pkg::BYTE_W-1:0] mem_rdata,
  input wire logic mem_ack
);

  // architectural state
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [LATCH_W-1:0] latch_r;
  logic [LATCH_W-1:0] latch_nxt;
  logic [BYTE_W-1:0] fsp_r;
  logic [BYTE_W-1:0] fsp_nxt;
  logic bank_r;
  logic bank_nxt;

  // bus slave state
  bus_state_e bus_state_r;
  bus_state_e bus_state_nxt;
  logic [AVS_DATA_W-1:0] rdata_r;
  logic [AVS_DATA_W-1:0] rdata_nxt;
  logic mem_req_r;
  logic mem_req_nxt;
  logic mem_we_r;
  logic mem_we_nxt;
  logic [DADDR_W-1:0] mem_addr_r;
  logic [DADDR_W-1:0] mem_addr_nxt;
  logic [BYTE_W-1:0] mem_wdata_r;
  logic [BYTE_W-1:0] mem_wdata_nxt;

  // stack handshake
  logic push;
  logic pop;
  logic [PC_W-1:0] push_pc;
  logic [PC_W-1:0] top_pc;

  // decode helpers
  logic bus_req;
  logic bus_wr_done;
  logic wr_lane0;
  logic sel_indirect;
  logic ptr_is_self;
  logic [PC_W-1:0] pc_step;
  logic [PC_W-1:0] page_target;
  logic [BYTE_W-1:0] wbyte;

  // eight 13-bit entries, pointer has no path to the bus
  // kept in its own module so nothing else can reach the pointer
  return_stack u_stack (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .push(push),
    .pop(pop),
    .push_pc(push_pc),
    .top_pc(top_pc)
  );

  // request and target decode
  assign bus_req = avs_read | avs_write;
  assign sel_indirect = (avs_address == OFS_INDIRECT);
  assign ptr_is_self = (fsp_r == FSP_SELF);
  assign wbyte = avs_writedata[BYTE_W-1:0];
  // only lane 0 carries a register byte, other lanes are ignored
  assign wr_lane0 = avs_write && avs_byteenable[0];
  assign bus_wr_done = (bus_state_r == BUS_DONE) && wr_lane0;
  assign pc_step = pc_r + PC_ONE;
  // page bits from the latch above the 11-bit literal, one 2K page per branch
  assign page_target = {latch_r[PAGE_HI:PAGE_LO], branch_lit};

  // waitrequest drops only in the answering cycle
  assign avs_waitrequest = bus_req && (bus_state_r != BUS_DONE);
  assign avs_readdata = rdata_r;
  assign pc_out = pc_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;

  // low byte load: upper counter bits come from all five latch bits
  function automatic logic [PC_W-1:0] pc_load(
    input logic [LATCH_W-1:0] latch,
    input logic [BYTE_W-1:0] low
  );
    pc_load = {latch, low};
  endfunction

  // read mux; counter bits 12..8 have no path to the bus
  function automatic logic [AVS_DATA_W-1:0] reg_read(
    input logic [AVS_ADDR_W-1:0] addr,
    input logic [PC_W-1:0] pc,
    input logic bank,
    input logic [BYTE_W-1:0] fsp,
    input logic [LATCH_W-1:0] latch
  );
    logic [BYTE_W-1:0] status_byte;
    // only the bank bit is stored, the rest read as zero
    status_byte = 8'h00;
    status_byte[BANK_BIT] = bank;
    case (addr)
      OFS_PC_LOW: reg_read = byte_word(pc[BYTE_W-1:0]);
      OFS_STATUS: reg_read = byte_word(status_byte);
      OFS_FSP: reg_read = byte_word(fsp);
      OFS_PC_LATCH: reg_read = byte_word({3'h0, latch});
      OFS_INDIRECT: reg_read = byte_word(INDIRECT_SELF_DATA);
      default: reg_read = 32'h00000000; // unmapped reads as zero
    endcase
  endfunction

  // bus slave: idle, optional forward to data memory, one answering cycle
  always_comb
  begin
    bus_state_nxt = bus_state_r;
    rdata_nxt = rdata_r;
    mem_req_nxt = mem_req_r;
    mem_we_nxt = mem_we_r;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    case (bus_state_r)
      BUS_IDLE:
      begin
        if (bus_req)
        begin
          if (sel_indirect && !ptr_is_self)
          begin
            // no storage here, the access goes to the selected register
            mem_req_nxt = 1'b1;
            mem_we_nxt = wr_lane0;
            mem_addr_nxt = indirect_addr(bank_r, fsp_r);
            mem_wdata_nxt = wbyte;
            bus_state_nxt = BUS_MEM;
          end
          else
          begin
            // plain registers answer from the read mux; indirect with pointer at zero: read 00h, write dropped
            rdata_nxt = reg_read(avs_address, pc_r, bank_r, fsp_r, latch_r);
            bus_state_nxt = BUS_DONE;
          end
        end
      end
      BUS_MEM:
      begin
        // hold the memory request until the memory acknowledges
        if (mem_ack)
        begin
          mem_req_nxt = 1'b0;
          mem_we_nxt = 1'b0;
          rdata_nxt = byte_word(mem_rdata);
          bus_state_nxt = BUS_DONE;
        end
      end
      BUS_DONE:
      begin
        // master drops the request now; one still held starts a new access
        bus_state_nxt = BUS_IDLE;
      end
      default:
      begin
        // unreachable state: abandon any memory cycle
        bus_state_nxt = BUS_IDLE;
        mem_req_nxt = 1'b0;
        mem_we_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state_r <= BUS_IDLE;
      rdata_r <= 32'h00000000;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 9'h000;
      mem_wdata_r <= 8'h00;
    end
    else
    begin
      bus_state_r <= bus_state_nxt;
      rdata_r <= rdata_nxt;
      mem_req_r <= mem_req_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  // counter, latch, pointer and bank bit; a bus write to the low byte beats
  // the decoder command of that cycle, which keeps the two loads from mixing
  always_comb
  begin
    pc_nxt = pc_r;
    latch_nxt = latch_r; // stack traffic never reaches the latch
    fsp_nxt = fsp_r;
    bank_nxt = bank_r;
    push = 1'b0;
    pop = 1'b0;
    push_pc = pc_step;
    if (bus_wr_done)
    begin
      case (avs_address)
        OFS_STATUS: bank_nxt = wbyte[BANK_BIT];
        OFS_FSP: fsp_nxt = wbyte;
        OFS_PC_LATCH: latch_nxt = wbyte[LATCH_W-1:0];
        default: latch_nxt = latch_r;
      endcase
    end
    if (bus_wr_done && (avs_address == OFS_PC_LOW))
    begin
      pc_nxt = pc_load(latch_r, wbyte); // upper bits follow the latch
    end
    else
    begin
      // one command per cycle, so push and pop never meet
      case (seq_cmd)
        CMD_STEP: pc_nxt = pc_step;
        CMD_PCL_WRITE: pc_nxt = pc_load(latch_r, pcl_data);
        CMD_GOTO: pc_nxt = page_target;
        CMD_CALL:
        begin
          push = 1'b1; // return address is the next word
          push_pc = pc_step;
          pc_nxt = page_target;
        end
        CMD_VECTOR:
        begin
          push = 1'b1; // interrupted instruction resumes on return
          push_pc = pc_r;
          pc_nxt = INT_VECTOR;
        end
        CMD_RETURN, CMD_RETURN_WITH_LITERAL, CMD_RETURN_FROM_INTERRUPT:
        begin
          pop = 1'b1;
          pc_nxt = top_pc; // all 13 bits, page bits ignored
        end
        default: pc_nxt = pc_r;
      endcase
    end
  end

  // all resets clear the whole counter, upper bits included
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // stack contents are cleared inside the stack module
      pc_r <= PC_RST;
      latch_r <= LATCH_RST;
      fsp_r <= FSP_RST;
      bank_r <= BANK_RST;
    end
    else
    begin
      pc_r <= pc_nxt;
      latch_r <= latch_nxt;
      fsp_r <= fsp_nxt;
      bank_r <= bank_nxt;
    end
  end

endmodule // pc_sequencer

/* File: verif/pc_sequencer_sva.sv */
// port-level assertions for the program counter sequencer
// assumes it is bound to the top module from the bench, one clock domain
`timescale 1ns/100ps
module pc_sequencer_sva
  import pcseq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [pcseq_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pcseq_pkg::AVS_DATA_W-1:0] avs_writedata,
  input wire logic [pcseq_pkg::AVS_BE_W-1:0] avs_byteenable,
  input wire logic [pcseq_pkg::AVS_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire pcseq_pkg::seq_cmd_e seq_cmd,
  input wire logic [pcseq_pkg::LIT_W-1:0] branch_lit,
  input wire logic [pcseq_pkg::PC_W-1:0] pc_out,
  input wire logic mem_req,
  input wire logic mem_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a completed pc low write drops the decoder command, so exclude it
  wire logic pcl_hit = avs_write && !avs_waitrequest && avs_address == OFS_PC_LOW;
  wire logic [7:0] wlow = avs_writedata[7:0];

  property p_rst_pc;
    $rose(rst_n) |-> pc_out == PC_RST;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("pc not clear after reset");
  property p_pcl_wr;
    pcl_hit && avs_byteenable[0] |=> pc_out[7:0] == $past(wlow);
  endproperty
  a_pcl_wr: assert property (p_pcl_wr) else $error("pc low write lost");
  property p_goto;
    seq_cmd == CMD_GOTO && !pcl_hit |=> pc_out[10:0] == $past(branch_lit);
  endproperty
  a_goto: assert property (p_goto) else $error("goto target wrong");
  property p_call_ret;
    (seq_cmd == CMD_CALL && !pcl_hit) ##1 (seq_cmd == CMD_RETURN && !pcl_hit)
      |=> pc_out == $past(pc_out, 2) + PC_ONE;
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("return address wrong");
  property p_vector;
    seq_cmd == CMD_VECTOR && !pcl_hit |=> pc_out == INT_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("vector not taken");
  property p_plain_wait;
    (avs_read || avs_write) && avs_address != OFS_INDIRECT && avs_waitrequest
      |=> !avs_waitrequest;
  endproperty
  a_plain_wait: assert property (p_plain_wait) else $error("register answer late");
  property p_rd_hi;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_mem_wait;
    mem_req |-> avs_waitrequest;
  endproperty
  a_mem_wait: assert property (p_mem_wait) else $error("answer before memory");
  property p_mem_ack;
    mem_req && mem_ack |=> !mem_req && !avs_waitrequest;
  endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("memory ack not ended");
endmodule // pc_sequencer_sva

/* File: verif/pc_sequencer_tb_top.sv */
// self-checking bench for the program counter sequencer
// assumes the bench plays bus master, decoder and data memory
`timescale 1ns/100ps
module pc_sequencer_tb_top;
  import pcseq_pkg::*;
  logic core_clk = 0;
  logic rst_n = 0;
  logic [4:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic [3:0] avs_byteenable = 0;
  logic avs_waitrequest, mem_req, mem_we;
  logic mem_ack = 0;
  seq_cmd_e seq_cmd = CMD_NONE;
  logic [10:0] branch_lit = 0;
  logic [7:0] pcl_data = 0;
  logic [7:0] mem_rdata = 0;
  logic [7:0] mem_wdata;
  logic [7:0] mem_m [512];
  logic [12:0] pc_out;
  logic [8:0] mem_addr;
  bit go;
  int mismatches = 0;
  int tests_run = 0;
  int pc, latch, ptr, bank, sp;
  int st [8];

  pc_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .seq_cmd(seq_cmd), .branch_lit(branch_lit),
    .pcl_data(pcl_data), .pc_out(pc_out), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // 20 mhz core clock
  always #25 core_clk = ~core_clk;

  task automatic end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // one avalon cycle; the decoder idles so no command is dropped
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    seq_cmd <= CMD_NONE;
    @(posedge core_clk);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    // held until waitrequest is sampled low at a rising edge
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1, a, d, be, q);
    if (be[0] && a == OFS_PC_LOW)
      pc = latch * 256 + d;
    if (be[0] && a == OFS_STATUS)
      bank = d[7];
    if (be[0] && a == OFS_FSP)
      ptr = d;
    if (be[0] && a == OFS_PC_LATCH)
      latch = d[4:0];
  endtask

  task automatic rdc(input logic [4:0] a, input int exp, input string what);
    logic [31:0] q;
    bus(0, a, 8'h00, 4'hf, q);
    chk(q, exp, what);
  endtask

  // called just after a rising edge; the command is taken at the next one
  task automatic cmd(input seq_cmd_e c, input logic [10:0] l, input logic [7:0] p);
    seq_cmd <= c;
    branch_lit <= l;
    pcl_data <= p;
    @(posedge core_clk);
    if (c == CMD_CALL || c == CMD_VECTOR)
    begin
      st[sp] = (c == CMD_CALL) ? (pc + 1) % 8192 : pc;
      sp = (sp + 1) % 8;
    end
    if (c >= CMD_RETURN && c <= CMD_RETURN_FROM_INTERRUPT)
    begin
      sp = (sp + 7) % 8;
      pc = st[sp];
    end
    case (c)
      CMD_STEP: pc = (pc + 1) % 8192;
      CMD_PCL_WRITE: pc = latch * 256 + p;
      CMD_GOTO, CMD_CALL: pc = (latch & 24) * 256 + l;
      CMD_VECTOR: pc = 4;
      default: ;
    endcase
  endtask

  // pc compared with the model every cycle, where both have settled
  always @(negedge core_clk)
    if (rst_n)
      chk(pc_out, pc, "pc");

  // data memory with random stalls; lines show noise when not answering
  always @(posedge core_clk)
  begin
    go = mem_req && !mem_ack && ($urandom % 3 == 0);
    mem_ack <= go;
    mem_rdata <= go ? mem_m[mem_addr] : 8'($urandom);
    if (mem_req && mem_ack && mem_we)
      mem_m[mem_addr] <= mem_wdata;
    if (mem_req)
      chk(mem_addr, ptr == 0 ? -1 : bank * 256 + ptr, "mem addr");
  end

  // watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    void'($urandom(89748));
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    rdc(OFS_PC_LOW, 0, "pc low after reset");
    wr(OFS_PC_LATCH, 8'h1f, 4'hf);
    wr(OFS_PC_LOW, 8'h55, 4'hf);
    wr(OFS_PC_LOW, 8'haa, 4'he);
    rdc(OFS_PC_LOW, 8'h55, "pc low read");
    wr(OFS_PC_LATCH, 8'h18, 4'hf);
    for (int i = 0; i < 20; i++)
      cmd(i < 10 ? CMD_CALL : CMD_RETURN, 11'($urandom), 8'h00);
    rdc(OFS_PC_LATCH, 8'h18, "latch kept");
    for (int i = 0; i < 400; i++)
    begin
      if (i % 25 == 0)
        wr(OFS_PC_LATCH, 8'($urandom), 4'hf);
      cmd(seq_cmd_e'($urandom % 9), 11'($urandom), 8'($urandom));
    end
    rdc(OFS_PC_LATCH, latch, "latch after stack traffic");
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_STATUS, 8'($urandom), 4'hf);
      wr(OFS_FSP, 8'($urandom % 255 + 1), 4'hf);
      wr(OFS_INDIRECT, 8'(i * 37 + 5), 4'hf);
      rdc(OFS_INDIRECT, i * 37 + 5, "indirect");
      rdc(OFS_STATUS, bank * 128, "bank bit");
    end
    wr(OFS_FSP, 8'h00, 4'hf);
    wr(OFS_INDIRECT, 8'h77, 4'hf);
    rdc(OFS_INDIRECT, 0, "indirect self");
    rdc(OFS_FSP, 0, "pointer kept");
    rdc(5'h14, 0, "unmapped");
    cmd(CMD_CALL, 11'h7ff, 8'h00);
    seq_cmd <= CMD_NONE;
    rst_n <= 0;
    pc = 0;
    latch = 0;
    sp = 0;
    ptr = 0;
    bank = 0;
    st = '{default: 0};
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    cmd(CMD_RETURN, 11'h000, 8'h00);
    seq_cmd <= CMD_NONE;
    repeat (2) @(posedge core_clk);
    rdc(OFS_STATUS, bank * 128, "bank after reset");
    rdc(OFS_PC_LATCH, latch, "latch after reset");
    end_sim();
  end
endmodule // pc_sequencer_tb_top

bind pc_sequencer pc_sequencer_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq_cmd(seq_cmd),
  .branch_lit(branch_lit), .pc_out(pc_out), .mem_req(mem_req), .mem_ack(mem_ack));
